// >>> core/tct_pkg.sv
// Port map, control word layout and timing constants of the interval timer
package tct_pkg;
  // Byte-wide I/O ports
  localparam logic [7:0] CNT0_ADDR = 8'h40;
  localparam logic [7:0] CNT1_ADDR = 8'h41;
  localparam logic [7:0] CNT2_ADDR = 8'h42;
  localparam logic [7:0] CTRL_ADDR = 8'h43;
  localparam int         NUM_CHAN  = 3;

  // Control word fields
  localparam int CW_SEL_LO  = 6;
  localparam int CW_RW_LO   = 4;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD     = 0;
  localparam int RB_COUNT_N  = 5;
  localparam int RB_STATUS_N = 4;
  localparam int RB_SEL_LO   = 1;

  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH     = 2'h0;
  localparam logic [1:0] RW_LSB       = 2'h1;
  localparam logic [1:0] RW_MSB       = 2'h2;
  localparam logic [1:0] RW_BOTH      = 2'h3;

  // Counting modes
  localparam logic [2:0] MODE0 = 3'h0;
  localparam logic [2:0] MODE1 = 3'h1;
  localparam logic [2:0] MODE2 = 3'h2;
  localparam logic [2:0] MODE3 = 3'h3;
  localparam logic [2:0] MODE4 = 3'h4;
  localparam logic [2:0] MODE5 = 3'h5;
  localparam logic [2:0] MODE_23_KEEP = 3'h3;

  // Stored control: {rw, mode, bcd}
  localparam logic [5:0] CTRL_RESET = 6'h10;

  // Counting tick derived from core clock
  localparam int CLK_FREQ_KHZ  = 50000;
  localparam int TICK_FREQ_KHZ = 1000;
  localparam int TICK_DIV      = CLK_FREQ_KHZ / TICK_FREQ_KHZ;

  typedef enum logic {PHASE_LOW, PHASE_HIGH} tct_phase_t;
endpackage : tct_pkg

// >>> core/tct_chan_if.sv
// Signals between the port decoder and one counter channel
`timescale 1ns/1ps
interface tct_chan_if;
  logic        ctrlWr;
  logic        latchCmd;
  logic        rbCount;
  logic        rbStatus;
  logic        dataWr;
  logic        dataRd;
  logic [7:0]  ioByte;
  logic        tick;
  logic        gate;
  logic [7:0]  rdByte;
  logic [7:0]  statusByte;
  logic [15:0] liveCount;
  logic [15:0] latchCount;
  logic        latchHeld;
  logic        out;

  modport host (
    output ctrlWr, latchCmd, rbCount, rbStatus, dataWr, dataRd, ioByte, tick, gate,
    input  rdByte, statusByte, liveCount, latchCount, latchHeld, out
  );
  modport chan (
    input  ctrlWr, latchCmd, rbCount, rbStatus, dataWr, dataRd, ioByte, tick, gate,
    output rdByte, statusByte, liveCount, latchCount, latchHeld, out
  );
endinterface : tct_chan_if

// >>> core/tct_counter.sv
// One counter channel: control, count, latch and byte sequencing
`timescale 1ns/1ps
module tct_counter (
  // Clock and reset
  input  logic   core_clk,
  input  logic   rst,
  // Decoder side
  tct_chan_if.chan bus
);
  logic [5:0]  ctrl,      next_ctrl;
  logic [15:0] count,     next_count;
  logic [15:0] reload,    next_reload;
  logic [15:0] latchVal,  next_latchVal;
  logic [7:0]  statusVal, next_statusVal;
  logic [7:0]  wrLow,     next_wrLow;
  logic        latchHeld, next_latchHeld;
  logic        statHeld,  next_statHeld;
  logic        loadPend,  next_loadPend;
  logic        armed,     next_armed;
  logic        running,   next_running;
  logic        nullCount, next_nullCount;
  logic        outLvl,    next_outLvl;
  logic        gateLast,  next_gateLast;
  logic        trigPend,  next_trigPend;
  tct_pkg::tct_phase_t wrPhase, next_wrPhase;
  tct_pkg::tct_phase_t rdPhase, next_rdPhase;
  logic [1:0]  rwMode;
  logic [2:0]  mode;
  logic        gated;
  logic        trigger;
  logic        loadEvent;
  logic        wrDone;
  logic [15:0] src;

  function automatic logic [15:0] decCount(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r = v - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      r = v;
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (v[4*d +: 4] == 4'h0) begin
            r[4*d +: 4] = 4'h9;
          end else begin
            r[4*d +: 4] = v[4*d +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : decCount

  assign rwMode = ctrl[5:4];
  assign mode   = ctrl[3:1];
  assign gated  = (mode == tct_pkg::MODE1) || (mode == tct_pkg::MODE5);
  assign src    = latchHeld ? latchVal : count;

  always_comb begin
    next_ctrl = ctrl;         next_count = count;       next_reload = reload;
    next_latchVal = latchVal; next_statusVal = statusVal;
    next_wrLow = wrLow;       next_latchHeld = latchHeld; next_statHeld = statHeld;
    next_loadPend = loadPend; next_armed = armed;       next_running = running;
    next_nullCount = nullCount; next_outLvl = outLvl;   next_wrPhase = wrPhase;
    next_rdPhase = rdPhase;
    trigger       = bus.gate && !gateLast;
    next_gateLast = bus.gate;
    next_trigPend = trigPend || trigger;
    wrDone        = 1'b0;
    loadEvent     = 1'b0;
    if (bus.ctrlWr) begin
      // Modes 2 and 3 ignore the top mode bit
      next_ctrl = {bus.ioByte[5:4],
                   bus.ioByte[2] ? (bus.ioByte[3:1] & tct_pkg::MODE_23_KEEP) : bus.ioByte[3:1],
                   bus.ioByte[tct_pkg::CW_BCD]};
      next_wrPhase = tct_pkg::PHASE_LOW;
      next_rdPhase = tct_pkg::PHASE_LOW;
      next_loadPend = 1'b0;
      next_armed = 1'b0;
      next_running = 1'b0;
      next_nullCount = 1'b1;
      next_latchHeld = 1'b0;
      next_statHeld = 1'b0;
      next_outLvl = (bus.ioByte[3:1] != tct_pkg::MODE0);
    end else begin
      if (bus.dataWr) begin
        case (rwMode)
          tct_pkg::RW_LSB: begin
            next_reload = {8'h00, bus.ioByte};
            wrDone = 1'b1;
          end
          tct_pkg::RW_MSB: begin
            next_reload = {bus.ioByte, 8'h00};
            wrDone = 1'b1;
          end
          default: begin
            if (wrPhase == tct_pkg::PHASE_LOW) begin
              next_wrLow = bus.ioByte;
              next_wrPhase = tct_pkg::PHASE_HIGH;
            end else begin
              next_reload = {bus.ioByte, wrLow};
              next_wrPhase = tct_pkg::PHASE_LOW;
              wrDone = 1'b1;
            end
          end
        endcase
        if (wrDone) begin
          next_loadPend = 1'b1;
          next_armed = 1'b1;
          next_nullCount = 1'b1;
        end
      end
      if (bus.tick) begin
        next_trigPend = 1'b0;
        loadEvent = gated ? ((trigPend || trigger) && armed) : loadPend;
        if (loadEvent) begin
          next_count = reload;
          next_running = 1'b1;
          next_loadPend = 1'b0;
          next_nullCount = 1'b0;
          next_outLvl = !((mode == tct_pkg::MODE0) || (mode == tct_pkg::MODE1));
        end else if (running && (gated || bus.gate)) begin
          // Binary or BCD step, chosen by the count type bit
          next_count = decCount(count, ctrl[tct_pkg::CW_BCD]);
          case (mode)
            tct_pkg::MODE0, tct_pkg::MODE1: begin
              if (count == 16'h0001) next_outLvl = 1'b1;
            end
            tct_pkg::MODE2: begin
              if (count == 16'h0002) next_outLvl = 1'b0;
              if (count == 16'h0001) begin
                next_count = reload;
                next_outLvl = 1'b1;
              end
            end
            tct_pkg::MODE3: begin
              next_count = decCount(decCount(count, ctrl[0]), ctrl[0]);
              if (count <= 16'h0002) begin
                next_count = reload;
                next_outLvl = !outLvl;
              end
            end
            default: begin
              next_outLvl = (count != 16'h0001);
            end
          endcase
        end
      end
      // Snapshot while the counter keeps running
      if ((bus.latchCmd || bus.rbCount) && !latchHeld) begin
        next_latchVal = count;
        next_latchHeld = 1'b1;
      end
      if (bus.rbStatus && !statHeld) begin
        next_statusVal = bus.statusByte;
        next_statHeld = 1'b1;
      end
      if (bus.dataRd) begin
        if (statHeld) begin
          next_statHeld = 1'b0;
        end else if ((rwMode == tct_pkg::RW_BOTH) && (rdPhase == tct_pkg::PHASE_LOW)) begin
          next_rdPhase = tct_pkg::PHASE_HIGH;
        end else begin
          next_rdPhase = tct_pkg::PHASE_LOW;
          next_latchHeld = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= tct_pkg::CTRL_RESET; count <= 16'h0000; reload <= 16'h0000;
      latchVal <= 16'h0000; statusVal <= 8'h00; wrLow <= 8'h00;
      latchHeld <= 1'b0; statHeld <= 1'b0; loadPend <= 1'b0; armed <= 1'b0;
      running <= 1'b0; nullCount <= 1'b1; outLvl <= 1'b0; gateLast <= 1'b0;
      trigPend <= 1'b0; wrPhase <= tct_pkg::PHASE_LOW; rdPhase <= tct_pkg::PHASE_LOW;
    end else begin
      ctrl <= next_ctrl; count <= next_count; reload <= next_reload;
      latchVal <= next_latchVal; statusVal <= next_statusVal; wrLow <= next_wrLow;
      latchHeld <= next_latchHeld; statHeld <= next_statHeld; loadPend <= next_loadPend;
      armed <= next_armed; running <= next_running; nullCount <= next_nullCount;
      outLvl <= next_outLvl; gateLast <= next_gateLast; trigPend <= next_trigPend;
      wrPhase <= next_wrPhase; rdPhase <= next_rdPhase;
    end
  end

  // Status first, then the latched or live count in programmed byte order
  assign bus.rdByte = statHeld ? statusVal :
                      ((rwMode == tct_pkg::RW_MSB) ||
                       ((rwMode == tct_pkg::RW_BOTH) && (rdPhase == tct_pkg::PHASE_HIGH)))
                      ? src[15:8] : src[7:0];
  assign bus.statusByte = {outLvl, nullCount, ctrl};
  assign bus.liveCount  = count;
  assign bus.latchCount = latchVal;
  assign bus.latchHeld  = latchHeld;
  assign bus.out        = outLvl;
endmodule : tct_counter

// >>> core/tct_timer_ports.sv
// Three-channel interval timer behind four byte-wide I/O ports
// What this block does
// - Ports 40h, 41h and 42h read and write the count of counters zero, one and two.
// - Port 43h takes the control word on write and gives no stored value on read.
// - Control bits 7:4 pick the counter and command; 00 in bits 5:4 latches, 11 in 7:6 is read-back.
// - Bits 5:4 set count access to low byte only, high byte only, or low then high.
// - Bits 3:1 set the counting mode, with the top bit ignored for modes two and three.
// - Bit 0 selects binary or binary coded decimal counting.
`timescale 1ns/1ps
module tct_timer_ports #(
  parameter int TICK_DIV = tct_pkg::TICK_DIV
) (
  // Clock and reset
  input  logic       core_clk,
  input  logic       rst,
  // Host I/O port access
  input  logic [7:0] ioAddr,
  input  logic       ioWr,
  input  logic       ioRd,
  input  logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic       ioRdValid,
  // Counter pins
  input  logic [2:0] gatePin,
  output logic [2:0] timerOut
);
  localparam int N     = tct_pkg::NUM_CHAN;
  localparam int DIV_W = $clog2(TICK_DIV);

  logic [DIV_W-1:0] divCnt, next_divCnt;
  logic             tick,   next_tick;
  logic [N-1:0]     gateS1, gateS2, gateS3, gateLvl, next_gateLvl;
  logic [7:0]       next_rdData;
  logic             next_rdValid;
  logic [N-1:0]     next_timerOut;
  logic             isCtrlWr;
  logic [1:0]       selField;
  logic [1:0]       rwField;
  logic [7:0]       chanRd     [N];
  logic [7:0]       chanStatus [N];
  logic [15:0]      chanLive   [N];
  logic [15:0]      chanLatch  [N];
  logic [N-1:0]     chanHeld;
  logic [N-1:0]     chanOut;

  // Counting rate as a one-cycle enable
  always_comb begin
    next_tick = 1'b0;
    next_divCnt = divCnt + 1'b1;
    if (divCnt == DIV_W'(TICK_DIV - 1)) begin
      next_divCnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divCnt <= '0;
      tick <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      tick <= next_tick;
    end
  end

  // Gate pins: a change counts once stages two and three agree
  always_comb begin
    next_gateLvl = gateLvl;
    for (int k = 0; k < N; k++) begin
      if (gateS2[k] == gateS3[k]) next_gateLvl[k] = gateS3[k];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gateS1 <= '0;
      gateS2 <= '0;
      gateS3 <= '0;
      gateLvl <= '0;
    end else begin
      gateS1 <= gatePin;
      gateS2 <= gateS1;
      gateS3 <= gateS2;
      gateLvl <= next_gateLvl;
    end
  end

  assign isCtrlWr = ioWr && (ioAddr == tct_pkg::CTRL_ADDR);
  assign selField = ioWrData[tct_pkg::CW_SEL_LO +: 2];
  assign rwField  = ioWrData[tct_pkg::CW_RW_LO +: 2];

  for (genvar i = 0; i < N; i++) begin : gen_chan
    tct_chan_if chanBus ();
    // Read-back selects by bit, the other commands by counter number
    assign chanBus.ctrlWr   = isCtrlWr && (selField == 2'(i)) &&
                              (rwField != tct_pkg::RW_LATCH);
    assign chanBus.latchCmd = isCtrlWr && (selField == 2'(i)) &&
                              (rwField == tct_pkg::RW_LATCH);
    assign chanBus.rbCount  = isCtrlWr && (selField == tct_pkg::SEL_READBACK) &&
                              !ioWrData[tct_pkg::RB_COUNT_N] &&
                              ioWrData[tct_pkg::RB_SEL_LO + i];
    assign chanBus.rbStatus = isCtrlWr && (selField == tct_pkg::SEL_READBACK) &&
                              !ioWrData[tct_pkg::RB_STATUS_N] &&
                              ioWrData[tct_pkg::RB_SEL_LO + i];
    assign chanBus.dataWr   = ioWr && (ioAddr == tct_pkg::CNT0_ADDR + 8'(i));
    assign chanBus.dataRd   = ioRd && (ioAddr == tct_pkg::CNT0_ADDR + 8'(i));
    assign chanBus.ioByte   = ioWrData;
    assign chanBus.tick     = tick;
    assign chanBus.gate     = gateLvl[i];
    assign chanRd[i]        = chanBus.rdByte;
    assign chanStatus[i]    = chanBus.statusByte;
    assign chanLive[i]      = chanBus.liveCount;
    assign chanLatch[i]     = chanBus.latchCount;
    assign chanHeld[i]      = chanBus.latchHeld;
    assign chanOut[i]       = chanBus.out;

    tct_counter u_counter (
      .core_clk (core_clk),
      .rst      (rst),
      .bus      (chanBus.chan)
    );
  end

  // Read answer one cycle after the strobe; foreign ports get no answer
  always_comb begin
    next_rdData = 8'h00;
    next_rdValid = 1'b0;
    next_timerOut = chanOut;
    if (ioRd) begin
      for (int k = 0; k < N; k++) begin
        if (ioAddr == tct_pkg::CNT0_ADDR + 8'(k)) begin
          next_rdData = chanRd[k];
          next_rdValid = 1'b1;
        end
      end
      if (ioAddr == tct_pkg::CTRL_ADDR) next_rdValid = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ioRdData <= 8'h00;
      ioRdValid <= 1'b0;
      timerOut <= '0;
    end else begin
      ioRdData <= next_rdData;
      ioRdValid <= next_rdValid;
      timerOut <= next_timerOut;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_ctrl0;
    isCtrlWr && (selField == 2'h0) && (rwField != tct_pkg::RW_LATCH);
  endsequence
  sequence s_ctrl1;
    isCtrlWr && (selField == 2'h1) && (rwField != tct_pkg::RW_LATCH);
  endsequence
  sequence s_latch0;
    isCtrlWr && (selField == 2'h0) && (rwField == tct_pkg::RW_LATCH) && !chanHeld[0];
  endsequence
  sequence s_rd0;
    ioRd && (ioAddr == tct_pkg::CNT0_ADDR);
  endsequence
  sequence s_wr0;
    ioWr && (ioAddr == tct_pkg::CNT0_ADDR);
  endsequence
  // Read-back count latch of counter zero, only while no snapshot is pending
  sequence s_rbcount0;
    isCtrlWr && (selField == tct_pkg::SEL_READBACK) && !ioWrData[tct_pkg::RB_COUNT_N] &&
    ioWrData[tct_pkg::RB_SEL_LO] && !chanHeld[0];
  endsequence

  countRead_a: assert property (ioRd && (ioAddr == tct_pkg::CNT1_ADDR) |=>
    ioRdValid && (ioRdData == $past(chanRd[1])))
    else $error("count port read answer wrong");
  countRead0_a: assert property (s_rd0 |=> ioRdValid && (ioRdData == $past(chanRd[0])))
    else $error("counter zero read answer wrong");
  foreignRead_a: assert property (ioRd && ((ioAddr < tct_pkg::CNT0_ADDR) ||
    (ioAddr > tct_pkg::CTRL_ADDR)) |=> !ioRdValid && (ioRdData == 8'h00))
    else $error("foreign port read answered");
  dataWrKeep_a: assert property (s_wr0 |=> $stable(chanStatus[0][5:0]))
    else $error("count write changed the control setting");
  ctrlRead_a: assert property (ioRd && (ioAddr == tct_pkg::CTRL_ADDR) |=>
    ioRdValid && (ioRdData == 8'h00))
    else $error("control port read not zero");
  selectOther_a: assert property (s_ctrl1 |=> $stable(chanStatus[0][5:0]))
    else $error("control word reached the wrong counter");
  latchSet_a: assert property (isCtrlWr && (selField == 2'h2) &&
    (rwField == tct_pkg::RW_LATCH) |=> chanHeld[2])
    else $error("latch command did not hold counter two");
  latchNoProg_a: assert property (isCtrlWr && (selField == 2'h1) &&
    (rwField == tct_pkg::RW_LATCH) |=> $stable(chanStatus[1][5:0]))
    else $error("latch command reprogrammed counter one");
  rbLatch_a: assert property (s_rbcount0 |=> chanHeld[0] &&
    (chanLatch[0] == $past(chanLive[0])))
    else $error("read-back did not capture the count");
  rwField_a: assert property (s_ctrl0 |=>
    chanStatus[0][5:4] == $past(ioWrData[5:4]))
    else $error("access order not stored");
  modeField_a: assert property (s_ctrl0 ##0 ioWrData[2] |=>
    (chanStatus[0][3:1] == {1'b0, $past(ioWrData[2:1])}))
    else $error("mode two or three not normalised");
  outFollow_a: assert property (timerOut == $past(chanOut))
    else $error("counter output not registered");
  tickPulse_a: assert property (tick |=> !tick)
    else $error("counting enable longer than one cycle");
  bcdField_a: assert property (s_ctrl0 |=> chanStatus[0][0] == $past(ioWrData[0]))
    else $error("count type not stored");
  latchFreeze_a: assert property (s_latch0 |=>
    chanHeld[0] && (chanLatch[0] == $past(chanLive[0])))
    else $error("latch did not capture the running count");
  latchKeep_a: assert property (chanHeld[0] &&
    !(ioRd && (ioAddr == tct_pkg::CNT0_ADDR)) &&
    !(isCtrlWr && (selField == 2'h0) && (rwField != tct_pkg::RW_LATCH)) |=>
    $stable(chanLatch[0]) && chanHeld[0])
    else $error("latched count changed before it was read");
  // A one-cycle glitch on the pin must not reach the counters
  gateFilter_a: assert property ((gateLvl[0] != $past(gateLvl[0])) |->
    $past(gateS2[0] == gateS3[0]))
    else $error("gate level changed without two agreeing stages");
endmodule : tct_timer_ports

// >>> verification/tct_timer_ports_test.sv
// Self-checking testbench for the three-channel interval timer ports
`timescale 1ns/1ps
module tct_timer_ports_test;
  // Small tick divider keeps the count moving within a short run
  localparam int TB_TICK_DIV = 2;
  localparam int CYCLE_LIMIT = 5000;

  logic       core_clk;
  logic       rst;
  logic [7:0] ioAddr;
  logic       ioWr;
  logic       ioRd;
  logic [7:0] ioWrData;
  logic [7:0] ioRdData;
  logic       ioRdValid;
  logic [2:0] gatePin;
  logic [2:0] timerOut;
  int         failCount;
  int         numChecks;
  int         cycleCount;

  tct_timer_ports #(
    .TICK_DIV (TB_TICK_DIV)
  ) DUT (
    .core_clk  (core_clk),
    .rst       (rst),
    .ioAddr    (ioAddr),
    .ioWr      (ioWr),
    .ioRd      (ioRd),
    .ioWrData  (ioWrData),
    .ioRdData  (ioRdData),
    .ioRdValid (ioRdValid),
    .gatePin   (gatePin),
    .timerOut  (timerOut)
  );

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // A hang is cut short here rather than by a wall-clock limit
  always @(posedge core_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == CYCLE_LIMIT) begin
      failCount++;
      summarize();
    end
  end

  task automatic check8(input string what, input logic [7:0] expVal, input logic [7:0] gotVal);
    numChecks++;
    if (gotVal !== expVal) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", what, expVal, gotVal);
    end
  endtask : check8

  task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    ioWr     <= 1'b1;
    ioAddr   <= addr;
    ioWrData <= data;
    @(posedge core_clk);
    ioWr     <= 1'b0;
  endtask : io_write

  // Answer is registered: valid stands in the cycle after the strobe edge
  task automatic io_read(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(posedge core_clk);
    ioRd   <= 1'b1;
    ioAddr <= addr;
    @(posedge core_clk);
    ioRd   <= 1'b0;
    #1;
    valid = ioRdValid;
    data  = ioRdData;
  endtask : io_read

  task automatic read_expect(input string what, input logic [7:0] addr, input logic [7:0] expVal);
    logic [7:0] data;
    logic       valid;
    io_read(addr, data, valid);
    check8({what, " valid"}, 8'h01, {7'h00, valid});
    check8(what, expVal, data);
  endtask : read_expect

  task automatic test_port_map();
    logic [7:0] data;
    logic       valid;
    io_read(8'h3f, data, valid);
    check8("valid below map", 8'h00, {7'h00, valid});
    io_read(8'h44, data, valid);
    check8("valid above map", 8'h00, {7'h00, valid});
    read_expect("control read", tct_pkg::CTRL_ADDR, 8'h00);
  endtask : test_port_map

  // Every access, every mode code and both count types, spread over all three counters
  task automatic test_control_fields();
    logic [1:0] ctr;
    logic [1:0] rw;
    logic [2:0] mode;
    logic       bcd;
    logic [7:0] cw;
    logic [2:0] kept;
    logic [7:0] expSt;
    for (int i = 0; i < 24; i++) begin
      ctr  = 2'(i % 3);
      rw   = 2'((i / 3) % 3 + 1);
      mode = 3'(i / 3);
      bcd  = 1'(i % 2);
      cw   = {ctr, rw, mode, bcd};
      // Modes two and three drop the top mode bit
      kept = mode[1] ? {1'b0, mode[1:0]} : mode;
      // Output idles low only in mode zero; null count stands until a written count is loaded
      expSt = {mode != 3'h0, 1'b1, rw, kept, bcd};
      io_write(tct_pkg::CTRL_ADDR, cw);
      io_write(tct_pkg::CTRL_ADDR, 8'he0 | (8'h02 << ctr));
      read_expect("status", tct_pkg::CNT0_ADDR + 8'(ctr), expSt);
    end
  endtask : test_control_fields

  // Counter one with its gate low holds the loaded count
  task automatic test_access_orders();
    io_write(tct_pkg::CTRL_ADDR, 8'h70);
    io_write(tct_pkg::CNT1_ADDR, 8'h34);
    io_write(tct_pkg::CNT1_ADDR, 8'h12);
    repeat (10) @(posedge core_clk);
    io_write(tct_pkg::CTRL_ADDR, 8'h40);
    read_expect("pair low", tct_pkg::CNT1_ADDR, 8'h34);
    read_expect("pair high", tct_pkg::CNT1_ADDR, 8'h12);
    io_write(tct_pkg::CTRL_ADDR, 8'h50);
    io_write(tct_pkg::CNT1_ADDR, 8'h56);
    repeat (10) @(posedge core_clk);
    io_write(tct_pkg::CTRL_ADDR, 8'h40);
    read_expect("low only", tct_pkg::CNT1_ADDR, 8'h56);
    io_write(tct_pkg::CTRL_ADDR, 8'h60);
    io_write(tct_pkg::CNT1_ADDR, 8'h78);
    repeat (10) @(posedge core_clk);
    io_write(tct_pkg::CTRL_ADDR, 8'h40);
    read_expect("high only", tct_pkg::CNT1_ADDR, 8'h78);
  endtask : test_access_orders

  // Snapshot taken just above a high-byte boundary, read after the live count crossed it
  task automatic test_latch();
    logic [7:0] lowByte;
    logic       valid;
    io_write(tct_pkg::CTRL_ADDR, 8'h34);
    io_write(tct_pkg::CNT0_ADDR, 8'h10);
    io_write(tct_pkg::CNT0_ADDR, 8'h01);
    repeat (6) @(posedge core_clk);
    io_write(tct_pkg::CTRL_ADDR, 8'h00);
    io_read(tct_pkg::CNT0_ADDR, lowByte, valid);
    check8("latched low in range", 8'h01,
           {7'h00, valid && lowByte <= 8'h10 && lowByte >= 8'h08});
    repeat (60) @(posedge core_clk);
    read_expect("latched high", tct_pkg::CNT0_ADDR, 8'h01);
    io_write(tct_pkg::CTRL_ADDR, 8'h00);
    io_read(tct_pkg::CNT0_ADDR, lowByte, valid);
    read_expect("relatched high", tct_pkg::CNT0_ADDR, 8'h00);
    io_write(tct_pkg::CTRL_ADDR, 8'hd2);
    io_read(tct_pkg::CNT0_ADDR, lowByte, valid);
    read_expect("read-back high", tct_pkg::CNT0_ADDR, 8'h00);
    io_write(tct_pkg::CTRL_ADDR, 8'he2);
    // Mode two output high and count loaded, so null count clear
    read_expect("status after latch", tct_pkg::CNT0_ADDR, 8'hb4);
    check8("mode two output", 8'h01, {7'h00, timerOut[0]});
  endtask : test_latch

  // Counter two in mode zero, decimal counting: output rises once the count runs out
  task automatic test_out_bcd();
    logic [7:0] lowByte;
    logic       valid;
    logic       inRange;
    io_write(tct_pkg::CTRL_ADDR, 8'h91);
    io_write(tct_pkg::CNT2_ADDR, 8'h10);
    repeat (4) @(posedge core_clk);
    io_write(tct_pkg::CTRL_ADDR, 8'h80);
    io_read(tct_pkg::CNT2_ADDR, lowByte, valid);
    // A binary step from ten would show 0f or 0e here
    inRange = valid && (lowByte >= 8'h07) && (lowByte <= 8'h09);
    check8("decimal step", 8'h01, {7'h00, inRange});
    check8("output while counting", 8'h00, {7'h00, timerOut[2]});
    repeat (30) @(posedge core_clk);
    #1;
    check8("output after count", 8'h01, {7'h00, timerOut[2]});
  endtask : test_out_bcd

  initial begin
    failCount  = 0;
    numChecks  = 0;
    cycleCount = 0;
    rst        = 1'b1;
    ioAddr     = 8'h00;
    ioWr       = 1'b0;
    ioRd       = 1'b0;
    ioWrData   = 8'h00;
    gatePin    = 3'b101;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    test_port_map();
    test_control_fields();
    test_access_orders();
    test_out_bcd();
    test_latch();
    repeat (4) @(posedge core_clk);
    summarize();
  end
endmodule : tct_timer_ports_test
